// File: logic/mdim_pkg.sv
// constants for the mode dependent interrupt masking block
// assumes a big-endian storage port with byte lanes, lane 3 = lowest byte address
package mdim_pkg;
    // ==========================================
    // processor figures
    localparam int CYCLE_NS = 115;
    localparam int DATA_W = 32;
    // ==========================================
    // register offsets
    localparam logic [7:0] REG_PSW_HI = 8'h00;
    localparam logic [7:0] REG_PSW_LO = 8'h04;
    localparam logic [7:0] REG_CR2 = 8'h08;
    localparam logic [7:0] REG_STS = 8'h0C;
    localparam logic [7:0] REG_MSK = 8'h10;
    localparam logic [7:0] REG_STATE = 8'h14;
    localparam logic [7:0] REG_CAW = 8'h18;
    // ==========================================
    // reset values
    localparam logic [31:0] PSW_HI_RST = 32'h0000_0000;
    localparam logic [31:0] PSW_LO_RST = 32'h0000_0000;
    localparam logic [31:0] CR2_RST = 32'hFFFF_FFFF;
    // ==========================================
    // field positions (status word bit n sits at index 31-n)
    localparam int PSW_CHM_HI = 31;
    localparam int PSW_SUM_IO = 25;
    localparam int PSW_EXT = 24;
    localparam int PSW_MODE = 19;
    localparam int CR2_CHM_HI = 31;
    localparam int STS_IO = 0;
    localparam int STS_IPL = 1;
    localparam int STS_INT = 2;
    localparam int STS_CAW = 3;
    localparam int STS_W = 4;
    // ==========================================
    // fixed low storage locations
    localparam logic [11:0] LOC_EXT_OLD = 12'h018;
    localparam logic [11:0] LOC_SVC_OLD = 12'h020;
    localparam logic [11:0] LOC_PGM_OLD = 12'h028;
    localparam logic [11:0] LOC_IO_OLD = 12'h038;
    localparam logic [11:0] LOC_CSW = 12'h040;
    localparam logic [11:0] LOC_CAW = 12'h048;
    localparam logic [11:0] LOC_EXT_CODE = 12'h084;
    localparam logic [11:0] LOC_SVC_CODE = 12'h088;
    localparam logic [11:0] LOC_PGM_CODE = 12'h08C;
    localparam logic [11:0] LOC_XLATE = 12'h090;
    localparam logic [11:0] LOC_PER = 12'h094;
    localparam logic [11:0] LOC_DEV = 12'h0B8;
    localparam logic [3:0] BE_WORD = 4'hF;
    localparam logic [3:0] BE_DEV = 4'h7;
    // ==========================================
    // kinds of interruption and states
    typedef enum logic [2:0] {K_IO, K_IPL, K_EXT, K_SVC, K_PGM} mdim_kind_e;
    typedef enum logic [1:0] {S_IDLE, S_STORE, S_FETCH} mdim_state_e;
endpackage

// File: logic/mdim_chan_gate.sv
// gate for one channel's interruption request
// assumes mode and mask bits already taken from the current status word and control register 2
`timescale 1ns/100ps
`default_nettype none
module mdim_chan_gate (
    // request
    input wire logic req,
    // mode and masks
    input wire logic ext_mode,
    input wire logic sum_io,
    input wire logic psw_mask,
    input wire logic cr_mask,
    // result
    output logic allow
);
    // ==========================================
    // masking
    always_comb begin
        if (ext_mode) begin
            allow = req & sum_io & cr_mask;
        end else begin
            allow = req & psw_mask;
        end
    end
endmodule
`default_nettype wire

// File: logic/mdim_top.sv
// mode dependent interrupt masking and low storage allocation
// assumes one clock, synchronous inputs, and a storage port that never stalls
// Behaviour
// - extended mode: channel allowed only with summary I/O bit 6 and its own bit
// - extended mode channel bits come from control register 2 bits 0 to 5
// - legacy mode: channels 0 to 5 gated only by status word bits 0 to 5
// - extended mode: channel masks, length and codes moved out above address 127
// - device address stored at 185 to 187 only in extended mode
// - extended mode stores length, codes, event data, device and translation address
// - channel status word stored at 64, channel address word fetched from 72
// - every command accepted in both modes, mode changes only interpretation
// - extended mode: one summary bit enables a whole interruption class
// - processor cycle 115 ns with a four byte data path
// - status word bit 12 one selects extended mode, zero legacy mode
// - initial program reset enters legacy mode
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module mdim_top import mdim_pkg::*; #(
    parameter int CHANNELS = 6
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // channel requests
    input wire logic [CHANNELS-1:0] io_req,
    input wire logic [15:0] io_dev_addr,
    input wire logic [63:0] csw_in,
    output logic io_ack,
    output logic [2:0] io_ack_chan,
    // other interruptions
    input wire logic int_req,
    input wire logic [1:0] int_kind,
    input wire logic [15:0] int_code,
    input wire logic [1:0] int_ilc,
    input wire logic [31:0] xlate_addr,
    input wire logic [7:0] per_code,
    // load and start
    input wire logic ipl_req,
    input wire logic [15:0] ipl_dev,
    input wire logic caw_req,
    // storage port
    output logic mem_we,
    output logic mem_re,
    output logic [11:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic [3:0] mem_be,
    input wire logic [31:0] mem_rdata,
    // status
    output logic busy,
    output logic irq
);
    // ==========================================
    // state
    typedef struct packed {
        logic [31:0] psw_hi;
        logic [31:0] psw_lo;
        logic [31:0] cr2;
        logic [STS_W-1:0] sts;
        logic [STS_W-1:0] msk;
        mdim_state_e st;
        mdim_kind_e kind;
        logic [2:0] step;
        logic ec;
        logic [2:0] chan;
        logic [15:0] dev;
        logic [15:0] code;
        logic [1:0] ilc;
        logic [63:0] channel_status_word;
        logic [31:0] xaddr;
        logic [7:0] per;
        logic [31:0] channel_address_word;
        logic mem_we;
        logic mem_re;
        logic [11:0] mem_addr;
        logic [31:0] mem_wdata;
        logic [3:0] mem_be;
        logic io_ack;
        logic [2:0] io_ack_chan;
        logic [31:0] rdata;
        logic irq;
        logic busy;
    } mdim_s;

    mdim_s r;
    mdim_s next_r;

    // ==========================================
    // channel gating
    logic ec_mode;
    logic [CHANNELS-1:0] allow;
    logic any_io;
    logic [2:0] pick;

    assign ec_mode = r.psw_hi[PSW_MODE];

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
            mdim_chan_gate u_gate (
                .req(io_req[gi]),
                .ext_mode(ec_mode),
                .sum_io(r.psw_hi[PSW_SUM_IO]),
                .psw_mask(r.psw_hi[PSW_CHM_HI-gi]),
                .cr_mask(r.cr2[CR2_CHM_HI-gi]),
                .allow(allow[gi])
            );
        end
    endgenerate

    always_comb begin
        any_io = 1'b0;
        pick = 3'h0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (allow[i]) begin
                any_io = 1'b1;
                pick = 3'(i);
            end
        end
    end

    // ==========================================
    // storage step table
    logic [11:0] s_addr;
    logic [31:0] s_data;
    logic [3:0] s_be;
    logic s_last;
    logic [31:0] old_hi;
    logic [31:0] old_lo;
    logic [31:0] code_word;
    logic [11:0] old_loc;
    logic [11:0] code_loc;

    always_comb begin
        old_hi = r.psw_hi;
        old_lo = r.psw_lo;
        if (!r.ec) begin
            old_hi[15:0] = r.kind == K_IO ? r.dev : r.code;
            old_lo[31:30] = r.ilc;
        end
        code_word = {14'h0000, r.ilc, r.code};
        case (r.kind)
            K_EXT: begin
                old_loc = LOC_EXT_OLD;
                code_loc = LOC_EXT_CODE;
            end
            K_SVC: begin
                old_loc = LOC_SVC_OLD;
                code_loc = LOC_SVC_CODE;
            end
            K_PGM: begin
                old_loc = LOC_PGM_OLD;
                code_loc = LOC_PGM_CODE;
            end
            default: begin
                old_loc = LOC_IO_OLD;
                code_loc = LOC_DEV;
            end
        endcase
        s_addr = old_loc;
        s_data = old_hi;
        s_be = BE_WORD;
        s_last = 1'b0;
        case (r.step)
            3'h0: begin
                if (r.kind == K_IPL) begin
                    s_addr = LOC_DEV;
                    s_data = {8'h00, 5'h00, r.chan, r.dev};
                    s_be = BE_DEV;
                    s_last = 1'b1;
                end
            end
            3'h1: begin
                s_addr = old_loc + 12'h004;
                s_data = old_lo;
                s_last = !r.ec && r.kind != K_IO;
            end
            3'h2: begin
                if (r.kind == K_IO) begin
                    s_addr = LOC_CSW;
                    s_data = r.channel_status_word[63:32];
                end else begin
                    s_addr = code_loc;
                    s_data = code_word;
                    s_last = r.kind != K_PGM;
                end
            end
            3'h3: begin
                if (r.kind == K_IO) begin
                    s_addr = LOC_CSW + 12'h004;
                    s_data = r.channel_status_word[31:0];
                    s_last = !r.ec;
                end else begin
                    s_addr = LOC_XLATE;
                    s_data = r.xaddr;
                end
            end
            default: begin
                s_last = 1'b1;
                if (r.kind == K_IO) begin
                    s_addr = LOC_DEV;
                    s_data = {8'h00, 5'h00, r.chan, r.dev};
                    s_be = BE_DEV;
                end else begin
                    s_addr = LOC_PER;
                    s_data = {8'h00, r.per, 16'h0000};
                end
            end
        endcase
    end

    // ==========================================
    // next state
    logic [STS_W-1:0] ev;

    always_comb begin
        next_r = r;
        ev = '0;
        next_r.mem_we = 1'b0;
        next_r.mem_re = 1'b0;
        next_r.io_ack = 1'b0;
        next_r.rdata = 32'h0000_0000;
        // register writes, always accepted in either mode
        if (reg_wr) begin
            case (reg_addr)
                REG_PSW_HI: next_r.psw_hi = reg_wdata;
                REG_PSW_LO: next_r.psw_lo = reg_wdata;
                REG_CR2: next_r.cr2 = reg_wdata;
                REG_MSK: next_r.msk = reg_wdata[STS_W-1:0];
                default: next_r.msk = r.msk;
            endcase
        end
        // register reads
        if (reg_rd) begin
            case (reg_addr)
                REG_PSW_HI: next_r.rdata = r.psw_hi;
                REG_PSW_LO: next_r.rdata = r.psw_lo;
                REG_CR2: next_r.rdata = r.cr2;
                REG_STS: next_r.rdata = {28'h0000000, r.sts};
                REG_MSK: next_r.rdata = {28'h0000000, r.msk};
                REG_STATE: next_r.rdata = {24'h000000, r.chan, r.kind, r.ec, ec_mode};
                REG_CAW: next_r.rdata = r.channel_address_word;
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end
        // sequencer
        case (r.st)
            S_IDLE: begin
                next_r.step = 3'h0;
                next_r.ec = ec_mode;
                if (ipl_req) begin
                    ev[STS_IPL] = 1'b1;
                    next_r.kind = K_IPL;
                    next_r.dev = ipl_dev;
                    next_r.chan = 3'(ipl_dev[10:8]);
                    if (ec_mode) begin
                        next_r.st = S_STORE;
                    end
                end else if (int_req && (int_kind != 2'h0 || r.psw_hi[PSW_EXT])) begin
                    next_r.kind = int_kind == 2'h0 ? K_EXT :
                        (int_kind == 2'h1 ? K_SVC : K_PGM);
                    next_r.code = int_code;
                    next_r.ilc = int_ilc;
                    next_r.xaddr = xlate_addr;
                    next_r.per = per_code;
                    next_r.st = S_STORE;
                end else if (any_io) begin
                    next_r.kind = K_IO;
                    next_r.chan = pick;
                    next_r.dev = io_dev_addr;
                    next_r.code = 16'h0000;
                    next_r.ilc = 2'h0;
                    next_r.channel_status_word = csw_in;
                    next_r.io_ack = 1'b1;
                    next_r.io_ack_chan = pick;
                    next_r.st = S_STORE;
                end else if (caw_req) begin
                    next_r.mem_re = 1'b1;
                    next_r.mem_addr = LOC_CAW;
                    next_r.mem_be = BE_WORD;
                    next_r.st = S_FETCH;
                end
            end
            S_STORE: begin
                next_r.mem_we = 1'b1;
                next_r.mem_addr = s_addr;
                next_r.mem_wdata = s_data;
                next_r.mem_be = s_be;
                next_r.step = r.step + 3'h1;
                if (s_last) begin
                    next_r.st = S_IDLE;
                    ev[STS_IO] = r.kind == K_IO;
                    ev[STS_INT] = r.kind != K_IO && r.kind != K_IPL;
                end
            end
            S_FETCH: begin
                if (!r.mem_re) begin
                    next_r.channel_address_word = mem_rdata;
                    ev[STS_CAW] = 1'b1;
                    next_r.st = S_IDLE;
                end
            end
            default: next_r.st = S_IDLE;
        endcase
        // sticky status, a new event wins over the clear
        if (reg_wr && reg_addr == REG_STS) begin
            next_r.sts = r.sts & ~reg_wdata[STS_W-1:0];
        end
        next_r.sts = next_r.sts | ev;
        next_r.irq = |(next_r.sts & next_r.msk);
        next_r.busy = next_r.st != S_IDLE;
    end

    // ==========================================
    // registers
    always_ff @(posedge clock) begin
        if (rst) begin
            r <= '0;
            r.psw_hi <= PSW_HI_RST;
            r.psw_lo <= PSW_LO_RST;
            r.cr2 <= CR2_RST;
            r.st <= S_IDLE;
            r.kind <= K_IO;
        end else begin
            r <= next_r;
        end
    end

    // ==========================================
    // outputs
    assign reg_rdata = r.rdata;
    assign io_ack = r.io_ack;
    assign io_ack_chan = r.io_ack_chan;
    assign mem_we = r.mem_we;
    assign mem_re = r.mem_re;
    assign mem_addr = r.mem_addr;
    assign mem_wdata = r.mem_wdata;
    assign mem_be = r.mem_be;
    assign irq = r.irq;
    assign busy = r.busy;
endmodule
`default_nettype wire

// File: bench/mdim_mem_model.sv
// storage partner for the masking block
// assumes word aligned byte addresses below 256 and big-endian byte lanes
`timescale 1ns/100ps
`default_nettype none
module mdim_mem_model (
    // clock
    input wire logic clock,
    // storage port
    input wire logic mem_we,
    input wire logic mem_re,
    input wire logic [11:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] mem_be,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [64];
    initial begin
        for (int i = 0; i < 64; i++) mem[i] = 32'hA5A5_0000 + 32'(i);
        mem_rdata = 32'h0;
    end
    // read data only in the cycle after the read, else a changing pattern
    always @(posedge clock) begin
        mem_rdata <= mem_re ? mem[mem_addr[7:2]] : ~mem_rdata;
        for (int b = 0; b < 4; b++)
            if (mem_we && mem_be[b]) mem[mem_addr[7:2]][8*b+:8] <= mem_wdata[8*b+:8];
    end
endmodule
`default_nettype wire

// File: bench/mdim_top_sva.sv
// port checker for the masking block
// assumes binding into mdim_top; mode and masks shadowed from register writes
`timescale 1ns/100ps
`default_nettype none
module mdim_checker import mdim_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // design outputs
    input wire logic io_ack,
    input wire logic [2:0] io_ack_chan,
    input wire logic mem_we,
    input wire logic mem_re,
    input wire logic [11:0] mem_addr,
    input wire logic [3:0] mem_be,
    input wire logic busy,
    input wire logic irq
);
    typedef struct packed {
        logic [31:0] program_status_word, cr2, msk, psw_q, cr2_q;
    } mdim_shadow_s;
    mdim_shadow_s r, next_r;
    // ==========================================
    // shadow registers
    always_comb begin
        next_r = r;
        next_r.psw_q = r.program_status_word;
        next_r.cr2_q = r.cr2;
        if (reg_wr && reg_addr == REG_PSW_HI) next_r.program_status_word = reg_wdata;
        if (reg_wr && reg_addr == REG_CR2) next_r.cr2 = reg_wdata;
        if (reg_wr && reg_addr == REG_MSK) next_r.msk = reg_wdata;
        if (rst) next_r = '{PSW_HI_RST, CR2_RST, 32'h0, PSW_HI_RST, CR2_RST};
    end
    always_ff @(posedge clock) begin
        r <= next_r;
    end
    // ==========================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_io_store;
        mem_we && mem_addr == LOC_IO_OLD ##1 mem_we && mem_addr == LOC_IO_OLD + 12'h004
        ##1 mem_we && mem_addr == LOC_CSW && mem_be == BE_WORD
        ##1 mem_we && mem_addr == LOC_CSW + 12'h004;
    endsequence
    chk_legacy_gate: assert property (
        io_ack && !r.psw_q[PSW_MODE] |-> r.psw_q[PSW_CHM_HI - io_ack_chan])
        else $error("legacy channel taken with its mask off");
    chk_ext_gate: assert property (
        io_ack && r.psw_q[PSW_MODE] |-> r.psw_q[PSW_SUM_IO] && r.cr2_q[CR2_CHM_HI - io_ack_chan])
        else $error("extended channel taken while masked");
    chk_io_store: assert property (io_ack |=> s_io_store)
        else $error("old status and channel status word not stored in order");
    chk_ext_dev: assert property (
        io_ack && r.psw_q[PSW_MODE] |-> ##5 mem_we && mem_addr == LOC_DEV && mem_be == BE_DEV)
        else $error("device address not stored in extended mode");
    chk_dev_mode: assert property (mem_we && mem_addr == LOC_DEV |-> r.program_status_word[PSW_MODE])
        else $error("device address stored in legacy mode");
    chk_caw_addr: assert property (mem_re |-> mem_addr == LOC_CAW && !mem_we)
        else $error("channel address word fetched from wrong place");
    chk_ack_pulse: assert property (io_ack |-> busy ##1 !io_ack)
        else $error("channel acknowledge not a single busy cycle");
    chk_irq_mask: assert property (r.msk[STS_W-1:0] == 4'h0 |-> !irq)
        else $error("interrupt raised with all events masked");
    chk_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside the read answer cycle");
endmodule
bind mdim_top mdim_checker i_mdim_checker (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .io_ack, .io_ack_chan, .mem_we, .mem_re, .mem_addr, .mem_be, .busy,
    .irq);
`default_nettype wire

// File: bench/tb.sv
// testbench for the masking block
// assumes the storage partner model and the bound port checker
`timescale 1ns/100ps
`default_nettype none
module tb import mdim_pkg::*;;
    logic clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic int_req = 1'b0, ipl_req = 1'b0, caw_req = 1'b0;
    logic io_ack, mem_we, mem_re, busy, irq;
    logic [7:0] reg_addr = '0, per_code = '0;
    logic [31:0] reg_wdata = '0, xlate_addr = '0, reg_rdata, mem_rdata, mem_wdata;
    logic [5:0] io_req = '0;
    logic [15:0] io_dev_addr = '0, int_code = '0, ipl_dev = '0;
    logic [63:0] csw_in = '0;
    logic [1:0] int_kind = '0, int_ilc = '0;
    logic [2:0] io_ack_chan;
    logic [11:0] mem_addr;
    logic [3:0] mem_be;
    int fails = 0, num_checks = 0;
    always #5 clock = ~clock;
    mdim_top i_mdim_top (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .io_req, .io_dev_addr, .csw_in, .io_ack, .io_ack_chan, .int_req, .int_kind, .int_code,
        .int_ilc, .xlate_addr, .per_code, .ipl_req, .ipl_dev, .caw_req, .mem_we, .mem_re,
        .mem_addr, .mem_wdata, .mem_be, .mem_rdata, .busy, .irq);
    mdim_mem_model i_mdim_mem_model (.clock, .mem_we, .mem_re, .mem_addr, .mem_wdata, .mem_be,
        .mem_rdata);
    // ==========================================
    // helpers
    function automatic logic [31:0] m(int a);
        return i_mdim_mem_model.mem[a / 4];
    endfunction
    function automatic logic [31:0] fresh(int a);
        return 32'hA5A5_0000 + 32'(a / 4);
    endfunction
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rdchk(string what, logic [7:0] a, logic [31:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 check(what, exp, reg_rdata);
    endtask
    task automatic settle;
        #1;
        for (int i = 0; i < 40 && busy !== 1'b0; i++) begin
            @(posedge clock);
            #1;
        end
        check("idle", 32'h0, {31'h0, busy});
        repeat (2) @(posedge clock);
    endtask
    task automatic take(logic [5:0] req, logic [2:0] ch);
        @(posedge clock);
        io_req <= req;
        for (int i = 0; i < 40 && io_ack !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        check("ack", 32'h1, {31'h0, io_ack});
        check("channel", {29'h0, ch}, {29'h0, io_ack_chan});
        @(posedge clock);
        io_req <= '0;
        settle();
    endtask
    task automatic go(logic [2:0] s);
        @(posedge clock);
        {ipl_req, int_req, caw_req} <= s;
        @(posedge clock);
        {ipl_req, int_req, caw_req} <= '0;
        settle();
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset;
        rdchk("state", REG_STATE, 32'h0);
        rdchk("cr2", REG_CR2, CR2_RST);
        rdchk("unmapped", 8'h1C, 32'h0);
    endtask
    task automatic t_legacy;
        wr(REG_CR2, 32'h0);
        wr(REG_PSW_HI, 32'h1000_0000);
        io_dev_addr <= 16'h0123;
        csw_in <= 64'h1122_3344_5566_7788;
        take(6'h0B, 3'h3);
        check("old psw dev", 32'h0123, m(56) & 32'hFFFF);
        check("csw high", 32'h1122_3344, m(64));
        check("csw low", 32'h5566_7788, m(68));
        int_kind <= 2'h1;
        int_code <= 16'hBEEF;
        int_ilc <= 2'h2;
        go(3'b010);
        check("svc code", 32'hBEEF, m(32) & 32'hFFFF);
        check("svc ilc", 32'h2, m(36) >> 30);
        check("svc fixed", fresh(136), m(136));
        ipl_dev <= 16'h0234;
        go(3'b100);
        check("ipl dev", fresh(184), m(184));
    endtask
    task automatic t_ext;
        int n;
        n = 0;
        wr(REG_CR2, 32'h0800_0000);
        wr(REG_PSW_HI, 32'hFC08_0000);
        io_req <= 6'h3F;
        repeat (20) begin
            @(posedge clock);
            #1 n += int'(io_ack);
        end
        check("masked acks", 32'h0, 32'(n));
        @(posedge clock);
        io_req <= '0;
        wr(REG_PSW_HI, 32'hFE08_0000);
        io_dev_addr <= 16'h0456;
        take(6'h1F, 3'h4);
        check("io dev", 32'hA504_0456, m(184));
        int_kind <= 2'h2;
        int_code <= 16'h0011;
        xlate_addr <= 32'h1234_5678;
        go(3'b010);
        check("pgm code", 32'h0011, m(140) & 32'hFFFF);
        check("xlate", 32'h1234_5678, m(144));
        check("pgm old psw", 32'hFE08_0000, m(40));
        int_kind <= 2'h0;
        int_code <= 16'h1234;
        go(3'b010);
        check("ext masked", fresh(132), m(132));
        wr(REG_PSW_HI, 32'hFF08_0000);
        go(3'b010);
        check("ext code", 32'h0002_1234, m(132));
        check("ext old psw", 32'hFF08_0000, m(24));
        go(3'b100);
        check("ext ipl", 32'hA500_0234, m(184) & 32'hFF00_FFFF);
    endtask
    task automatic t_misc;
        go(3'b001);
        rdchk("caw", REG_CAW, fresh(72));
        rdchk("status", REG_STS, 32'hF);
        wr(REG_MSK, 32'h1);
        repeat (2) @(posedge clock);
        #1 check("irq on", 32'h1, {31'h0, irq});
        wr(REG_STS, 32'hF);
        repeat (2) @(posedge clock);
        #1 check("irq off", 32'h0, {31'h0, irq});
        rdchk("status clear", REG_STS, 32'h0);
    endtask
    task automatic t_rereset;
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rdchk("state after reset", REG_STATE, 32'h0);
        rdchk("psw after reset", REG_PSW_HI, PSW_HI_RST);
    endtask
    // ==========================================
    // run control
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        fails++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_legacy();
        t_ext();
        t_misc();
        t_rereset();
        end_of_test();
    end
endmodule
`default_nettype wire
